// [verilog/general_timer_channel.sv]
// One 16-bit general timer channel: timer, event counter and measurement modes
`timescale 1ns/1ps
`include "timer_channel_consts.svh"
// Overview of operation
// (R1) Timer mode counts peripheral clock /1, /8, /32 or subclock /32.
// (R2) Timer and event modes count down and reload on underflow.
// (R3) Underflow period is programmed value plus one counts.
// (R4) Counting runs while the start flag is 1, halts at 0.
// (R5) Timer and event modes pulse an interrupt at each underflow.
// (R6) Timer and event modes read back the live counter.
// (R7) Writing data while stopped loads reload register and counter.
// (R8) Writing data while counting loads only reload; counter gets it at underflow.
// (R9) Event mode counts the input pin or another timer's overflow.
// (R10) Pin event edge is rising, falling or both.
// (R11) Measurement mode counts internal clock up, timing period or width.
// (R12) Each effective edge copies counter into reload and restarts from zero.
// (R13) Measurement interrupts on each effective edge except the first.
// (R14) Measurement overflow raises interrupt and sets the overflow flag.
// (R15) Mode write while running clears overflow flag after next count cycle.
// (R16) Measurement mode reads back the reload register.
// (R17) Readback undefined until second effective edge after start.
// (R18) Measurement mode ignores data writes.
// (R19) Mode register bits 7:6 select timer, event or measurement mode.
// (R20) Period uses rising edges only, width uses every edge.
// (R21) Timer mode ignores the input pin.
module general_timer_channel #(
	parameter int WIDTH = `TMR_WIDTH
) (
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic                          count_start,
	input  wire logic                          mode_wr,
	input  wire timer_channel_pkg::mode_reg_type mode_wdata,
	input  wire logic                          data_wr,
	input  wire logic [WIDTH-1:0]              data_wdata,
	input  wire logic                          channel_input_pin,
	input  wire logic                          other_timer_ovf,
	input  wire logic                          subclock_tick,
	output logic [WIDTH-1:0]                   data_rdata,
	output timer_channel_pkg::mode_reg_type    mode_rdata,
	output logic                               overflow_flag,
	output logic                               irq
);
	import timer_channel_pkg::*;

	mode_reg_type     mode_ff, nxt_mode;
	logic [WIDTH-1:0] cnt_ff, nxt_cnt;
	logic [WIDTH-1:0] reload_ff, nxt_reload;
	logic [WIDTH-1:0] rdata_ff, nxt_rdata;
	logic             ovf_ff, nxt_ovf;
	logic             ovf_aged_ff, nxt_ovf_aged;
	logic             first_ff, nxt_first;
	logic             irq_ff, nxt_irq;
	logic             tick;
	logic             pin_rise, pin_fall;
	logic             count_evt, meas_edge, underflow;

	// Mode register bits 7:6 pick the mode; see (R19)
	timer_prescaler u_presc (
		.clk      (clk),
		.rst_n    (rst_n),
		.sel      (mode_ff.clk_src), // see (R1)
		.sub_tick (subclock_tick),
		.tick     (tick)
	);

	edge_detect u_edge (
		.clk   (clk),
		.rst_n (rst_n),
		.pin   (channel_input_pin),
		.rise  (pin_rise),
		.fall  (pin_fall)
	);

	function automatic logic edge_hit(input edge_sel_type sel, input logic r, input logic f);
		case (sel)
			edge_rise: edge_hit = r;
			edge_fall: edge_hit = f;
			edge_both: edge_hit = r | f;
			default:   edge_hit = 1'b0;
		endcase
	endfunction

	always_comb begin
		count_evt = 1'b0;
		meas_edge = 1'b0;
		case (mode_ff.mode)
			mode_timer:   count_evt = tick; // pin unused here, see (R21)
			mode_event: begin
				if (mode_ff.evt_from_timer) begin
					count_evt = other_timer_ovf; // see (R9)
				end else begin
					count_evt = edge_hit(mode_ff.evt_edge, pin_rise, pin_fall); // see (R10)
				end
			end
			mode_measure: begin
				count_evt = tick; // see (R11)
				// Period: rising to rising; width: every edge; see (R20)
				meas_edge = mode_ff.meas_width ? (pin_rise | pin_fall) : pin_rise;
			end
			default: begin
				count_evt = 1'b0;
				meas_edge = 1'b0;
			end
		endcase
		meas_edge = meas_edge & count_start;
	end

	assign underflow = count_start && count_evt && (cnt_ff == '0) &&
		(mode_ff.mode == mode_timer || mode_ff.mode == mode_event);

	always_comb begin
		nxt_mode     = mode_ff;
		nxt_cnt      = cnt_ff;
		nxt_reload   = reload_ff;
		nxt_ovf      = ovf_ff;
		nxt_ovf_aged = ovf_aged_ff;
		nxt_first    = first_ff;
		nxt_irq      = 1'b0;
		if (mode_wr) begin
			nxt_mode = mode_wdata;
		end
		if (!count_start) begin
			nxt_first = 1'b1;
		end
		case (mode_ff.mode)
			mode_timer, mode_event: begin
				if (count_start && count_evt) begin // see (R4)
					if (underflow) begin
						nxt_cnt = reload_ff; // n+1 counts per period, see (R2) (R3)
						nxt_irq = 1'b1;      // see (R5)
					end else begin
						nxt_cnt = cnt_ff - 1'b1;
					end
				end
				if (data_wr) begin
					nxt_reload = data_wdata; // see (R8)
					if (!count_start) begin
						nxt_cnt = data_wdata; // see (R7)
					end
				end
			end
			mode_measure: begin
				// Data writes are ignored, see (R18)
				if (meas_edge) begin
					nxt_reload = cnt_ff; // see (R12)
					nxt_cnt    = '0;
					nxt_first  = 1'b0;
					nxt_irq    = !first_ff; // see (R13)
				end else if (count_start && count_evt) begin
					nxt_cnt = cnt_ff + 1'b1;
					if (cnt_ff == '1) begin
						nxt_irq      = 1'b1; // see (R14)
						nxt_ovf      = 1'b1;
						nxt_ovf_aged = 1'b0;
					end else if (ovf_ff) begin
						nxt_ovf_aged = 1'b1;
					end
				end
			end
			default: nxt_cnt = cnt_ff;
		endcase
		// Clear only after a count cycle has passed since the overflow; set wins
		if (mode_wr && count_start && ovf_aged_ff && nxt_ovf_aged) begin // see (R15)
			nxt_ovf      = 1'b0;
			nxt_ovf_aged = 1'b0;
		end
		// Read mux: live count or measurement; early results undefined, see (R17)
		if (mode_ff.mode == mode_measure) begin
			nxt_rdata = nxt_reload; // see (R16)
		end else begin
			nxt_rdata = nxt_cnt; // see (R6)
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff     <= '0;
			cnt_ff      <= `TMR_CNT_RESET;
			reload_ff   <= `TMR_RELOAD_RESET;
			rdata_ff    <= `TMR_CNT_RESET;
			ovf_ff      <= 1'b0;
			ovf_aged_ff <= 1'b0;
			first_ff    <= 1'b1;
			irq_ff      <= 1'b0;
		end else begin
			mode_ff     <= nxt_mode;
			cnt_ff      <= nxt_cnt;
			reload_ff   <= nxt_reload;
			rdata_ff    <= nxt_rdata;
			ovf_ff      <= nxt_ovf;
			ovf_aged_ff <= nxt_ovf_aged;
			first_ff    <= nxt_first;
			irq_ff      <= nxt_irq;
		end
	end

	assign data_rdata    = rdata_ff;
	assign mode_rdata    = mode_ff;
	assign overflow_flag = ovf_ff;
	assign irq           = irq_ff;

	property p_underflow_reload;
		@(posedge clk) disable iff (!rst_n) underflow && !data_wr |=> cnt_ff == $past(reload_ff);
	endproperty
	a_underflow_reload: assert property (p_underflow_reload) else $error("no reload"); // see (R2)

	property p_underflow_irq;
		@(posedge clk) disable iff (!rst_n) underflow |=> irq;
	endproperty
	a_underflow_irq: assert property (p_underflow_irq) else $error("no irq"); // see (R5)

	property p_stopped_hold;
		@(posedge clk) disable iff (!rst_n) !count_start && !data_wr |=> cnt_ff == $past(cnt_ff);
	endproperty
	a_stopped_hold: assert property (p_stopped_hold) else $error("count moved"); // see (R4)

	property p_stopped_write;
		@(posedge clk) disable iff (!rst_n)
		data_wr && !count_start && mode_ff.mode != mode_measure
		|=> cnt_ff == $past(data_wdata) && reload_ff == $past(data_wdata);
	endproperty
	a_stopped_write: assert property (p_stopped_write) else $error("bad load"); // see (R7)

	property p_meas_nowrite;
		@(posedge clk) disable iff (!rst_n)
		mode_ff.mode == mode_measure && !meas_edge |=> reload_ff == $past(reload_ff);
	endproperty
	a_meas_nowrite: assert property (p_meas_nowrite) else $error("reload moved"); // see (R18)

	property p_meas_capture;
		@(posedge clk) disable iff (!rst_n)
		mode_ff.mode == mode_measure && meas_edge |=> reload_ff == $past(cnt_ff) && cnt_ff == '0;
	endproperty
	a_meas_capture: assert property (p_meas_capture) else $error("bad capture"); // see (R12)

	property p_first_edge_quiet;
		@(posedge clk) disable iff (!rst_n)
		mode_ff.mode == mode_measure && meas_edge && first_ff |=> !irq;
	endproperty
	a_first_edge_quiet: assert property (p_first_edge_quiet) else $error("first irq"); // see (R13)

	property p_ovf_set;
		@(posedge clk) disable iff (!rst_n)
		mode_ff.mode == mode_measure && count_start && count_evt && !meas_edge && cnt_ff == '1
		|=> overflow_flag && irq;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("no ovf"); // see (R14)

	property p_ovf_fresh;
		@(posedge clk) disable iff (!rst_n) $rose(ovf_ff) && !ovf_aged_ff && mode_wr |=> ovf_ff;
	endproperty
	a_ovf_fresh: assert property (p_ovf_fresh) else $error("early clear"); // see (R15)

	c_underflow: cover property (@(posedge clk) disable iff (!rst_n) underflow);
	c_meas_irq: cover property (@(posedge clk) disable iff (!rst_n) meas_edge && !first_ff);
	c_ovf: cover property (@(posedge clk) disable iff (!rst_n) $rose(ovf_ff));
	c_ovf_clr: cover property (@(posedge clk) disable iff (!rst_n) $fell(ovf_ff));
endmodule

// [verilog/timer_channel_consts.svh]
// Constants for the general timer channel: width, positions, reset values and prescaler terminal counts
`ifndef TIMER_CHANNEL_CONSTS_SVH
`define TIMER_CHANNEL_CONSTS_SVH
`define TMR_WIDTH        16
`define TMR_MODE_LSB     0
`define TMR_MODE_MSB     1
`define TMR_CNT_RESET    16'h0000
`define TMR_RELOAD_RESET 16'h0000
`define TMR_PRESC_DIV8   5'h07
`define TMR_PRESC_DIV32  5'h1F
`define TMR_SUB_DIV32    5'h1F
`endif

// [verilog/timer_channel_pkg.sv]
// Types shared by the general timer channel
package timer_channel_pkg;
	typedef enum logic [1:0] {
		mode_timer   = 2'h0,
		mode_event   = 2'h1,
		mode_measure = 2'h2,
		mode_rsvd    = 2'h3
	} mode_type;
	typedef enum logic [1:0] {
		src_div1  = 2'h0,
		src_div8  = 2'h1,
		src_div32 = 2'h2,
		src_sub32 = 2'h3
	} clk_src_type;
	typedef enum logic [1:0] {
		edge_rise = 2'h0,
		edge_fall = 2'h1,
		edge_both = 2'h2,
		edge_rsvd = 2'h3
	} edge_sel_type;
	typedef struct packed {
		mode_type     mode;
		clk_src_type  clk_src;
		logic         evt_from_timer;
		edge_sel_type evt_edge;
		logic         meas_width;
	} mode_reg_type;
endpackage

// [verilog/timer_prescaler.sv]
// Internal count source prescaler: peripheral clock div 1/8/32, subclock div 32
`timescale 1ns/1ps
`include "timer_channel_consts.svh"
module timer_prescaler (
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	input  wire timer_channel_pkg::clk_src_type sel,
	input  wire logic                         sub_tick,
	output logic                              tick
);
	import timer_channel_pkg::*;
	logic [4:0] div_ff, nxt_div;
	logic [4:0] sub_ff, nxt_sub;
	logic       tick_c;

	always_comb begin
		nxt_div = div_ff + 5'h01;
		nxt_sub = sub_ff;
		if (sub_tick) begin
			nxt_sub = sub_ff + 5'h01;
		end
		case (sel)
			src_div1:  tick_c = 1'b1;
			src_div8:  tick_c = (div_ff[2:0] == `TMR_PRESC_DIV8'(3'h7));
			src_div32: tick_c = (div_ff == `TMR_PRESC_DIV32);
			src_sub32: tick_c = sub_tick && (sub_ff == `TMR_SUB_DIV32);
			default:   tick_c = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_ff <= 5'h00;
			sub_ff <= 5'h00;
		end else begin
			div_ff <= nxt_div;
			sub_ff <= nxt_sub;
		end
	end
	assign tick = tick_c;
endmodule

// [verilog/edge_detect.sv]
// Two-stage synchroniser for an outside pin with rise and fall pulses
`timescale 1ns/1ps
module edge_detect (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin,
	output logic      rise,
	output logic      fall
);
	logic s1_ff, s2_ff, s3_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
		end else begin
			s1_ff <= pin;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end
	// Only the second and third stages feed the comparators
	assign rise = s2_ff & ~s3_ff;
	assign fall = ~s2_ff & s3_ff;
endmodule

// [tb/pulse_source.sv]
// Far-side model: input pin pulse train, other-timer overflow and subclock ticks
`timescale 1ns/1ps
module pulse_source (
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic [7:0] half,
	input  wire logic [7:0] pulses,
	input  wire logic       ovf_run,
	output logic            pin,
	output logic            busy,
	output logic            ovf,
	output logic            sub_tick
);
	int phase = 0;
	int left = 0;
	int div = 0;
	initial begin
		pin = 1'b0;
		busy = 1'b0;
		ovf = 1'b0;
		sub_tick = 1'b0;
	end
	// Outputs move on the falling edge, away from the sampling edge
	always @(negedge clk) begin
		div <= div + 1;
		sub_tick <= (div % 2 == 1);
		ovf <= ovf_run && (div % 4 == 0);
		if (go && !busy) begin
			left <= int'(pulses) * 2;
			phase <= 0;
			busy <= 1'b1;
		end else if (busy) begin
			if (phase + 1 == int'(half)) begin
				phase <= 0;
				pin <= ~pin;
				left <= left - 1;
				if (left == 1) begin
					busy <= 1'b0;
				end
			end else begin
				phase <= phase + 1;
			end
		end
	end
endmodule

// [tb/general_timer_b_channel_bench.sv]
// Self-checking bench for the general timer channel
`timescale 1ns/1ps
module general_timer_b_channel_bench;
	import timer_channel_pkg::*;
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	logic         count_start = 1'b0;
	logic         mode_wr = 1'b0;
	logic         data_wr = 1'b0;
	logic         go = 1'b0;
	logic         ovf_run = 1'b0;
	mode_reg_type mode_wdata = '0;
	logic [15:0]  data_wdata = 16'h0000;
	logic [7:0]   half = 8'h14;
	logic [7:0]   pulses = 8'h08;
	logic         pin, busy, ovf, sub_tick, overflow_flag, irq;
	logic [15:0]  data_rdata, held;
	mode_reg_type mode_rdata;
	int           failures = 0;
	int           checks_done = 0;
	int           irq_seen = 0;
	int           gap;
	clk_src_type  srcs [3] = '{src_div8, src_div32, src_sub32};
	int           per [3] = '{8, 32, 64};
	edge_sel_type edges [3] = '{edge_rise, edge_fall, edge_both};
	int           hits [3] = '{4, 4, 8};

	general_timer_channel #(.WIDTH(16)) dut_u (
		.clk(clk), .rst_n(rst_n), .count_start(count_start), .mode_wr(mode_wr),
		.mode_wdata(mode_wdata), .data_wr(data_wr), .data_wdata(data_wdata),
		.channel_input_pin(pin), .other_timer_ovf(ovf), .subclock_tick(sub_tick),
		.data_rdata(data_rdata), .mode_rdata(mode_rdata),
		.overflow_flag(overflow_flag), .irq(irq));
	pulse_source partner_u (
		.clk(clk), .go(go), .half(half), .pulses(pulses), .ovf_run(ovf_run),
		.pin(pin), .busy(busy), .ovf(ovf), .sub_tick(sub_tick));

	initial begin
		forever #2 clk = ~clk;
	end
	always @(negedge clk) begin
		if (irq === 1'b1) irq_seen++;
	end

	task automatic summarize();
		$display("checks %0d, failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic set_mode(input mode_type m, input clk_src_type s, input logic t,
			input edge_sel_type e, input logic w);
		@(negedge clk);
		mode_wdata = '{m, s, t, e, w};
		mode_wr = 1'b1;
		@(negedge clk);
		mode_wr = 1'b0;
	endtask
	task automatic write_data(input logic [15:0] v);
		@(negedge clk);
		data_wdata = v;
		data_wr = 1'b1;
		@(negedge clk);
		data_wr = 1'b0;
		@(negedge clk);
	endtask
	task automatic wait_irq(output int n);
		for (n = 1; n <= 200; n++) begin
			@(negedge clk);
			if (irq === 1'b1) return;
		end
		failures++;
		summarize();
	endtask
	// Pulse train, then room for the pin synchroniser lag
	task automatic pulse_run();
		int i;
		// Let any earlier train finish so only this one is counted
		for (i = 0; i < 2000 && busy === 1'b1; i++) @(negedge clk);
		repeat (8) @(negedge clk);
		irq_seen = 0;
		// Model samples go on the same edge, so drive it race-free
		go <= 1'b1;
		@(negedge clk);
		go <= 1'b0;
		@(negedge clk);
		for (i = 0; i < 2000 && busy === 1'b1; i++) @(negedge clk);
		repeat (8) @(negedge clk);
	endtask

	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		check(data_rdata, 16'h0000);
		check({9'h000, mode_rdata}, 16'h0000);
		check({15'h0000, overflow_flag}, 16'h0000);
		set_mode(mode_timer, src_div1, 1'b0, edge_rise, 1'b0);
		check({9'h000, mode_rdata}, {9'h000, mode_wdata});
		write_data(16'h0005);
		check(data_rdata, 16'h0005);
		go = 1'b1;
		count_start = 1'b1;
		wait_irq(gap);
		go = 1'b0;
		wait_irq(gap);
		check(gap, 16'h0006);
		write_data(16'h0002);
		wait_irq(gap);
		wait_irq(gap);
		check(gap, 16'h0003);
		held = data_rdata;
		@(negedge clk);
		check(data_rdata !== held, 16'h0001);
		count_start = 1'b0;
		repeat (2) @(negedge clk);
		held = data_rdata;
		repeat (10) @(negedge clk);
		check(data_rdata, held);
		for (int i = 0; i < 3; i++) begin
			set_mode(mode_timer, srcs[i], 1'b0, edge_rise, 1'b0);
			write_data(16'h0000);
			count_start = 1'b1;
			wait_irq(gap);
			wait_irq(gap);
			check(gap, per[i]);
			count_start = 1'b0;
		end
		set_mode(mode_event, src_div1, 1'b1, edge_rise, 1'b0);
		write_data(16'h0001);
		count_start = 1'b1;
		ovf_run = 1'b1;
		wait_irq(gap);
		wait_irq(gap);
		check(gap, 16'h0008);
		ovf_run = 1'b0;
		count_start = 1'b0;
		for (int i = 0; i < 3; i++) begin
			set_mode(mode_event, src_div1, 1'b0, edges[i], 1'b0);
			write_data(16'h0001);
			count_start = 1'b1;
			irq_seen = 0;
			pulse_run();
			check(irq_seen, hits[i]);
			count_start = 1'b0;
		end
		set_mode(mode_measure, src_div1, 1'b0, edge_rise, 1'b0);
		count_start = 1'b1;
		irq_seen = 0;
		pulse_run();
		check(irq_seen, 16'h0007);
		check(data_rdata >= 39 && data_rdata <= 40, 16'h0001);
		held = data_rdata;
		write_data(16'h1234);
		check(data_rdata, held);
		count_start = 1'b0;
		set_mode(mode_measure, src_div1, 1'b0, edge_rise, 1'b1);
		count_start = 1'b1;
		irq_seen = 0;
		pulse_run();
		check(irq_seen, 16'h000F);
		check(data_rdata >= 19 && data_rdata <= 20, 16'h0001);
		for (int i = 0; i < 70000 && overflow_flag !== 1'b1; i++) @(negedge clk);
		if (overflow_flag !== 1'b1) begin
			failures++;
			summarize();
		end
		check({15'h0000, irq}, 16'h0001);
		set_mode(mode_measure, src_div1, 1'b0, edge_rise, 1'b1);
		@(negedge clk);
		check({15'h0000, overflow_flag}, 16'h0000);
		summarize();
	end
endmodule
